// ### hdl/remap_consts.svh
/*
  Register indexes, field positions and reset values of the remote alias
  remapping block. Assumes it is included by bare name before use.
*/
`ifndef REMAP_CONSTS_SVH
`define REMAP_CONSTS_SVH

// Register indexes; byte address on the bus is four times the index
`define RM_IDX_PHYS6 8'h3f
`define RM_IDX_PHYS7 8'h40
`define RM_IDX_ALIAS0 8'h41
`define RM_IDX_ALIAS1 8'h42
`define RM_IDX_ALIAS2 8'h43
`define RM_IDX_ALIAS3 8'h44

// Field layout of the slot registers; auto-ack bit used by alias slots only
`define RM_ADDR_MSB 7
`define RM_ADDR_LSB 1
`define RM_AUTO_ACK_BIT 0

// Reset values
`define RM_ADDR_RST 7'h00
`define RM_AUTO_RST 1'b0
`define RM_ALIAS_OFF 7'h00

// Bus width and slot count
`define RM_BUS_AW 10
`define RM_SLOTS 4

`endif

// ### hdl/remap_pkg.sv
/*
  Types of the remote alias remapping block.
  Assumes nothing of its surroundings.
*/
package remap_pkg;

  // Address byte seen by the local I2C decoder
  typedef struct packed {
    logic [6:0] addr;
    logic rnw;
  } i2c_addr_t;

  // Transaction handed to the control channel
  typedef struct packed {
    logic [6:0] addr;
    logic rnw;
    logic [1:0] slot;
  } fwd_req_t;

  // Result of the alias compare
  typedef struct packed {
    logic hit;
    logic [1:0] slot;
  } match_t;

  // Transaction tracking, Gray along idle, active, refused
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_ACT = 2'b01,
    ST_NACK = 2'b11
  } remap_state_t;

endpackage

// ### hdl/alias_match.sv
/*
  Compares an incoming 7-bit I2C address with the four alias slots.
  Assumes the alias values come from registers on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none

`include "remap_consts.svh"

module alias_match
  import remap_pkg::*;
(
  input wire logic [6:0] addr,
  input wire logic [3:0][6:0] alias_tab,
  output var match_t result
);

  // Lowest matching slot wins; a zero alias never matches
  always_comb begin
    result = '0;
    for (int i = 3; i >= 0; i--) begin
      if (alias_tab[i] != `RM_ALIAS_OFF && alias_tab[i] == addr) begin
        result.hit = 1'b1;
        result.slot = 2'(i);
      end
    end
  end

endmodule

`default_nettype wire

// ### hdl/avmm_slave.sv
/*
  Avalon-MM slave handshake with one wait state for reads and writes.
  Assumes the master holds its request until it sees waitrequest low.
*/
`timescale 1ns/1ps
`default_nettype none

module avmm_slave (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic read,
  input wire logic write,
  input wire logic [7:0] rdata_in,
  output logic [31:0] readdata,
  output logic waitrequest,
  output logic wr_go
);

  // Write commits at the edge where the master sees waitrequest low
  assign wr_go = write && !waitrequest;

  // Waitrequest drops for one cycle after a request is seen
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      waitrequest <= 1'b1;
    end else if ((read || write) && waitrequest) begin
      waitrequest <= 1'b0;
    end else begin
      waitrequest <= 1'b1;
    end
  end

  // Read data captured with the drop of waitrequest
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      readdata <= 32'h0000_0000;
    end else if (read && waitrequest) begin
      readdata <= {24'h00_0000, rdata_in};
    end
  end

endmodule

`default_nettype wire

// ### hdl/i2c_remote_alias_remap.sv
/*
  Remote target alias remapping: alias and physical address registers on
  Avalon-MM, the alias decoder, the address rewrite toward the control
  channel and the local auto-acknowledge of writes.
  Assumes the local I2C decoder and the channel logic run on core_clk and
  that physical addresses of slots 0 to 3 come from the neighbouring
  register bank on the same clock.
*/
// Implementation choice: the Avalon-MM slave port.
`timescale 1ns/1ps
`default_nettype none

`include "remap_consts.svh"

// How it works
// - Physical target address stored in bits 7:1
// - Alias hit forwards the paired physical address
// - Alias in bits 7:1 compared by decoder
// - Zero alias disables slot, nothing forwarded
// - Auto-ack bit acknowledges writes locally
// - Reset clears addresses, aliases and auto-ack
module i2c_remote_alias_remap
  import remap_pkg::*;
(
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic [`RM_BUS_AW-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic [3:0][6:0] phys_addr_low,
  input wire logic txn_start,
  input wire i2c_addr_t txn_addr,
  input wire logic txn_byte,
  input wire logic txn_stop,
  input wire logic link_lock,
  input wire logic remote_ack_valid,
  input wire logic remote_ack,
  output logic fwd_valid_r,
  output var fwd_req_t fwd_r,
  output logic claim_r,
  output logic local_ack_valid_r,
  output logic local_ack_r,
  output logic [1:0][6:0] phys_addr_high_r
);

  // Register state
  logic [1:0][6:0] phys_r;
  logic [3:0][6:0] alias_r;
  logic [3:0] aack_r;

  // Transaction state
  remap_state_t state_r;
  remap_state_t state_nxt;
  logic pend_r;
  logic auto_r;
  logic rnw_r;

  // Bus side and alias match signals
  logic wr_go;
  logic [7:0] rdata;
  logic [7:0] widx;
  logic wr_lane;
  match_t hit;
  logic [6:0] phys_sel;

  // Word index of a byte address
  function automatic logic [7:0] word_idx(input logic [`RM_BUS_AW-1:0] a);
    word_idx = a[9:2];
  endfunction

  // Slot register image: address in 7:1, flag in bit 0
  function automatic logic [7:0] pack_slot(input logic [6:0] a,
                                           input logic f);
    pack_slot = {a, f};
  endfunction

  // Register read decode; reserved bits and holes read zero
  function automatic logic [7:0] reg_read(input logic [7:0] idx);
    case (idx)
      `RM_IDX_PHYS6: reg_read = pack_slot(phys_r[0], 1'b0);
      `RM_IDX_PHYS7: reg_read = pack_slot(phys_r[1], 1'b0);
      `RM_IDX_ALIAS0: reg_read = pack_slot(alias_r[0], aack_r[0]);
      `RM_IDX_ALIAS1: reg_read = pack_slot(alias_r[1], aack_r[1]);
      `RM_IDX_ALIAS2: reg_read = pack_slot(alias_r[2], aack_r[2]);
      `RM_IDX_ALIAS3: reg_read = pack_slot(alias_r[3], aack_r[3]);
      default: reg_read = 8'h00;
    endcase
  endfunction

  // Bus handshake
  avmm_slave u_bus (
    .core_clk(core_clk),
    .rstn(rstn),
    .read(avs_read),
    .write(avs_write),
    .rdata_in(rdata),
    .readdata(avs_readdata),
    .waitrequest(avs_waitrequest),
    .wr_go(wr_go)
  );

  // Read mux and write decode
  assign widx = word_idx(avs_address);
  assign wr_lane = wr_go && avs_byteenable[0];

  // Process form so a register change refreshes the mux at a steady index
  always_comb begin
    rdata = reg_read(widx);
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      phys_r <= {2{`RM_ADDR_RST}};
    end else if (wr_lane) begin
      if (widx == `RM_IDX_PHYS6) begin
        phys_r[0] <= avs_writedata[`RM_ADDR_MSB:`RM_ADDR_LSB];
      end
      if (widx == `RM_IDX_PHYS7) begin
        phys_r[1] <= avs_writedata[`RM_ADDR_MSB:`RM_ADDR_LSB];
      end
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      alias_r <= {4{`RM_ADDR_RST}};
      aack_r <= {4{`RM_AUTO_RST}};
    end else if (wr_lane) begin
      for (int i = 0; i < `RM_SLOTS; i++) begin
        if (widx == `RM_IDX_ALIAS0 + 8'(i)) begin
          alias_r[i] <= avs_writedata[`RM_ADDR_MSB:`RM_ADDR_LSB];
          aack_r[i] <= avs_writedata[`RM_AUTO_ACK_BIT];
        end
      end
    end
  end

  // Physical addresses of slots 6 and 7 for the upper alias bank
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      phys_addr_high_r <= '0;
    end else begin
      phys_addr_high_r <= phys_r;
    end
  end

  alias_match u_match (
    .addr(txn_addr.addr),
    .alias_tab(alias_r),
    .result(hit)
  );

  // Physical address paired with the hit slot
  assign phys_sel = phys_addr_low[hit.slot];

  // forward the rewritten address once per claimed transaction
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      fwd_valid_r <= 1'b0;
      fwd_r <= '0;
    end else begin
      fwd_valid_r <= 1'b0;
      if (txn_start && hit.hit && state_r == ST_IDLE) begin
        fwd_valid_r <= 1'b1;
        fwd_r <= '{addr: phys_sel, rnw: txn_addr.rnw, slot: hit.slot};
      end
    end
  end

  // Next state of the transaction tracker
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: begin
        if (txn_start && hit.hit) begin
          state_nxt = ST_ACT;
        end
      end
      ST_ACT: begin
        if (txn_stop) begin
          state_nxt = ST_IDLE;
        end else if (pend_r && !(auto_r && !rnw_r)) begin
          if (!link_lock || (remote_ack_valid && !remote_ack)) begin
            state_nxt = ST_NACK;
          end
        end
      end
      ST_NACK: begin
        if (txn_stop) begin
          state_nxt = ST_IDLE;
        end
      end
      default: state_nxt = ST_IDLE;
    endcase
  end

  // Tracker state
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      state_r <= ST_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Slot settings frozen for the whole transaction
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      auto_r <= 1'b0;
      rnw_r <= 1'b0;
    end else if (txn_start && hit.hit && state_r == ST_IDLE) begin
      auto_r <= aack_r[hit.slot];
      rnw_r <= txn_addr.rnw;
    end
  end

  // A byte awaits its acknowledge; new bytes win over completion
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      pend_r <= 1'b0;
    end else if (state_r == ST_IDLE) begin
      pend_r <= txn_start && hit.hit;
    end else if (state_r != ST_ACT || txn_stop) begin
      pend_r <= 1'b0;
    end else if (txn_byte) begin
      pend_r <= 1'b1;
    end else if (local_ack_valid_r || state_nxt != ST_ACT) begin
      pend_r <= 1'b0;
    end else if (pend_r && (auto_r && !rnw_r)) begin
      pend_r <= 1'b0;
    end else if (pend_r && remote_ack_valid) begin
      pend_r <= 1'b0;
    end
  end

  // local acknowledge: auto-ack on writes, else refused without link_lock, else remote answer
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      local_ack_valid_r <= 1'b0;
      local_ack_r <= 1'b0;
    end else begin
      local_ack_valid_r <= 1'b0;
      if (state_r == ST_ACT && pend_r && !txn_stop
          && !local_ack_valid_r) begin
        if (auto_r && !rnw_r) begin
          local_ack_valid_r <= 1'b1;
          local_ack_r <= 1'b1;
        end else if (!link_lock) begin
          local_ack_valid_r <= 1'b1;
          local_ack_r <= 1'b0;
        end else if (remote_ack_valid) begin
          local_ack_valid_r <= 1'b1;
          local_ack_r <= remote_ack;
        end
      end
    end
  end

  // Transaction owned by this block
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      claim_r <= 1'b0;
    end else begin
      claim_r <= (state_nxt != ST_IDLE);
    end
  end

  // Checks
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rstn);

  a_reset_clear:
  assert property (@(posedge core_clk) $rose(rstn) |->
    (alias_r == '0 && aack_r == '0 && phys_r == '0))
  else $error("slot registers not clear after reset");

  a_phys_store:
  assert property (wr_lane && widx == `RM_IDX_PHYS7 |=>
    phys_r[1] == $past(avs_writedata[7:1]))
  else $error("physical address write not stored");

  a_alias_store:
  assert property (wr_lane && widx == `RM_IDX_ALIAS2 |=>
    alias_r[2] == $past(avs_writedata[7:1])
    && aack_r[2] == $past(avs_writedata[0]))
  else $error("alias write not stored");

  a_remap_addr:
  assert property (txn_start && hit.hit && state_r == ST_IDLE |=>
    fwd_valid_r && fwd_r.addr == $past(phys_sel)
    && fwd_r.rnw == $past(txn_addr.rnw))
  else $error("forwarded address not remapped");

  a_zero_blocked:
  assert property (fwd_valid_r |-> $past(txn_start)
    && $past(txn_addr.addr) != `RM_ALIAS_OFF)
  else $error("zero alias forwarded");

  a_auto_ack:
  assert property (state_r == ST_ACT && pend_r && auto_r && !rnw_r
    && !txn_stop && !local_ack_valid_r |=>
    local_ack_valid_r && local_ack_r ##1 !local_ack_valid_r)
  else $error("auto acknowledge missing");

  a_nack_park:
  assert property (local_ack_valid_r && !local_ack_r |->
    state_r == ST_NACK || $past(txn_stop) || state_r == ST_IDLE)
  else $error("refused byte left transaction active");

endmodule

`default_nettype wire

// ### tb/remote_model.sv
/*
  Remote deserializer model: answers each forwarded address.
  Assumes fwd_valid is a one-cycle pulse on core_clk.
*/
`timescale 1ns/1ps
`default_nettype none

module remote_model (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic fwd_valid,
  input wire logic [3:0] delay,
  input wire logic ack_val,
  output logic ack_valid,
  output logic ack
);
  logic [3:0] cnt_r;
  logic busy_r;

  // Answer delay plus one cycles after the request; idle ack line toggles
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      busy_r <= 1'b0;
      cnt_r <= 4'h0;
      ack_valid <= 1'b0;
      ack <= 1'b0;
    end else begin
      ack_valid <= 1'b0;
      ack <= ~ack;
      if (fwd_valid) begin
        busy_r <= 1'b1;
        cnt_r <= delay;
      end else if (busy_r && cnt_r == 4'h0) begin
        busy_r <= 1'b0;
        ack_valid <= 1'b1;
        ack <= ack_val;
      end else if (busy_r) begin
        cnt_r <= cnt_r - 4'h1;
      end
    end
  end
endmodule
`default_nettype wire

// ### tb/tb_top.sv
/*
  Self-checking bench of the alias remapping block.
  Assumes the design files and the remote model are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
`include "remap_consts.svh"

`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin error_cnt++; \
  $display("[ERR] t=%0t got=%h exp=%h", $time, a, e); end end

module tb_top
  import remap_pkg::*;
;
  logic core_clk = 1'b0;
  logic rstn = 1'b0;
  logic [9:0] avs_address = 10'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0] avs_byteenable = 4'hf;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic [3:0][6:0] phys_low = '0;
  logic txn_start = 1'b0;
  i2c_addr_t txn_addr = '0;
  logic txn_stop = 1'b0;
  logic txn_byte = 1'b0;
  logic claim_seen = 1'b0;
  logic link_lock = 1'b1;
  logic rack_valid;
  logic rack;
  logic fwd_valid_r;
  fwd_req_t fwd_r;
  logic claim_r;
  logic local_ack_valid_r;
  logic local_ack_r;
  logic [1:0][6:0] phys_high;
  logic [3:0] p_delay = 4'h1;
  logic p_ack = 1'b1;
  int error_cnt = 0;
  int cmp_count = 0;

  // Clock of 10 ns
  always #5 core_clk = ~core_clk;

  i2c_remote_alias_remap i_dut (
    .core_clk(core_clk), .rstn(rstn), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .phys_addr_low(phys_low), .txn_start(txn_start),
    .txn_addr(txn_addr), .txn_byte(txn_byte), .txn_stop(txn_stop),
    .link_lock(link_lock), .remote_ack_valid(rack_valid),
    .remote_ack(rack), .fwd_valid_r(fwd_valid_r), .fwd_r(fwd_r),
    .claim_r(claim_r), .local_ack_valid_r(local_ack_valid_r),
    .local_ack_r(local_ack_r), .phys_addr_high_r(phys_high)
  );

  remote_model i_rem (
    .core_clk(core_clk), .rstn(rstn), .fwd_valid(fwd_valid_r),
    .delay(p_delay), .ack_val(p_ack), .ack_valid(rack_valid),
    .ack(rack)
  );

  // Verdict and end of run
  task automatic final_report();
    $display("checks=%0d mismatches=%0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // One Avalon-MM transfer, held until waitrequest is low
  task automatic bus(input logic wr, input logic [7:0] idx,
                     input logic [7:0] d, output logic [7:0] q);
    int n;
    n = 0;
    @(posedge core_clk);
    avs_address <= {idx, 2'b00};
    avs_read <= ~wr;
    avs_write <= wr;
    avs_writedata <= {24'h0, d};
    // Waitrequest and read data are taken at the same rising edge
    do begin
      @(posedge core_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    if (n >= 50) begin
      error_cnt++;
    end
    q = avs_readdata[7:0];
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask

  // Address phase, answer, then stop
  task automatic txn(input logic [6:0] a, input logic rnw,
                     output logic fv, output fwd_req_t f,
                     output logic ak);
    int n;
    fv = 1'b0;
    ak = 1'bx;
    f = '0;
    claim_seen = 1'b0;
    @(posedge core_clk);
    txn_start <= 1'b1;
    txn_addr <= '{addr: a, rnw: rnw};
    @(posedge core_clk);
    txn_start <= 1'b0;
    for (n = 0; n < 24; n++) begin
      @(negedge core_clk);
      if (fwd_valid_r === 1'b1) begin
        fv = 1'b1;
        f = fwd_r;
      end
      if (claim_r === 1'b1) begin
        claim_seen = 1'b1;
      end
      if (local_ack_valid_r === 1'b1) begin
        ak = local_ack_r;
        break;
      end
    end
    @(posedge core_clk);
    txn_stop <= 1'b1;
    @(posedge core_clk);
    txn_stop <= 1'b0;
    repeat (2) @(posedge core_clk);
  endtask

  // Reset values and an unmapped index
  task automatic t_reset();
    logic [7:0] q;
    for (int i = 8'h3e; i <= 8'h44; i++) begin
      bus(1'b0, 8'(i), 8'h0, q);
      `CHK(q, 8'h00)
    end
    `CHK(claim_r, 1'b0)
    $display("test reset done");
  endtask

  // Physical slots 6 and 7, reserved bit, masked write
  task automatic t_phys();
    logic [7:0] q;
    bus(1'b1, `RM_IDX_PHYS6, 8'ha5, q);
    bus(1'b1, `RM_IDX_PHYS7, 8'h7f, q);
    bus(1'b0, `RM_IDX_PHYS6, 8'h0, q);
    `CHK(q, 8'ha4)
    bus(1'b0, `RM_IDX_PHYS7, 8'h0, q);
    `CHK(q, 8'h7e)
    `CHK(phys_high, {7'h3f, 7'h52})
    avs_byteenable <= 4'he;
    bus(1'b1, `RM_IDX_PHYS6, 8'h12, q);
    avs_byteenable <= 4'hf;
    bus(1'b0, `RM_IDX_PHYS6, 8'h0, q);
    `CHK(q, 8'ha4)
    $display("test phys done");
  endtask

  // Zero alias and a miss forward nothing
  task automatic t_zero();
    logic fv;
    logic ak;
    fwd_req_t f;
    txn(7'h00, 1'b0, fv, f, ak);
    `CHK(fv, 1'b0)
    `CHK(claim_seen, 1'b0)
    txn(7'h33, 1'b1, fv, f, ak);
    `CHK(fv, 1'b0)
    `CHK(claim_seen, 1'b0)
    $display("test zero done");
  endtask

  // Every slot remaps to its physical address, slow and fast answers
  task automatic t_remap();
    logic [7:0] q;
    logic fv;
    logic ak;
    fwd_req_t f;
    for (int k = 0; k < 4; k++) begin
      phys_low[k] <= 7'(7'h60 + k);
      p_delay <= 4'(2 * k + 1);
      p_ack <= (k != 3);
      bus(1'b1, 8'(`RM_IDX_ALIAS0 + k), 8'(8'h20 + 2 * k), q);
      bus(1'b0, 8'(`RM_IDX_ALIAS0 + k), 8'h0, q);
      `CHK(q, 8'(8'h20 + 2 * k))
      txn(7'(7'h10 + k), 1'b1, fv, f, ak);
      `CHK(fv, 1'b1)
      `CHK(f, fwd_req_t'({7'(7'h60 + k), 1'b1, 2'(k)}))
      `CHK(ak, (k != 3))
      `CHK(claim_seen, 1'b1)
      `CHK(claim_r, 1'b0)
    end
    $display("test remap done");
  endtask

  // Local acknowledge of writes without lock, then cleared
  task automatic t_auto();
    logic [7:0] q;
    logic fv;
    logic ak;
    fwd_req_t f;
    link_lock <= 1'b0;
    p_ack <= 1'b0;
    bus(1'b1, `RM_IDX_ALIAS2, 8'h25, q);
    txn(7'h12, 1'b0, fv, f, ak);
    `CHK(ak, 1'b1)
    txn(7'h12, 1'b1, fv, f, ak);
    `CHK(ak, 1'b0)
    // auto-ack cleared again after debug use
    bus(1'b1, `RM_IDX_ALIAS2, 8'h24, q);
    txn(7'h12, 1'b0, fv, f, ak);
    `CHK(ak, 1'b0)
    link_lock <= 1'b1;
    $display("test auto done");
  endtask

  // A data byte after the address gets its own local acknowledge
  task automatic t_byte();
    logic [7:0] q;
    int n;
    n = 0;
    bus(1'b1, `RM_IDX_ALIAS0, 8'h21, q);
    @(posedge core_clk);
    txn_start <= 1'b1;
    txn_addr <= '{addr: 7'h10, rnw: 1'b0};
    for (int i = 0; i < 12; i++) begin
      @(posedge core_clk);
      txn_start <= 1'b0;
      txn_byte <= (i == 4);
      @(negedge core_clk);
      if (local_ack_valid_r === 1'b1 && local_ack_r === 1'b1) begin
        n++;
      end
    end
    @(posedge core_clk);
    txn_stop <= 1'b1;
    @(posedge core_clk);
    txn_stop <= 1'b0;
    repeat (2) @(posedge core_clk);
    `CHK(n, 2)
    `CHK(claim_r, 1'b0)
    // auto-ack cleared again after debug use
    bus(1'b1, `RM_IDX_ALIAS0, 8'h20, q);
    $display("test byte done");
  endtask

  // Reset in mid-run clears the slots written by earlier tests
  task automatic t_midreset();
    @(posedge core_clk);
    rstn <= 1'b0;
    repeat (4) @(posedge core_clk);
    rstn <= 1'b1;
    t_reset();
    `CHK(phys_high, 14'h0)
    $display("test midreset done");
  endtask

  // Watchdog
  initial begin
    #200us;
    error_cnt++;
    final_report();
  end

  // Main sequence
  initial begin
    repeat (4) @(posedge core_clk);
    rstn <= 1'b1;
    t_reset();
    t_phys();
    t_zero();
    t_remap();
    t_auto();
    t_byte();
    t_midreset();
    final_report();
  end
endmodule
`default_nettype wire
